// ---- logic/icp_cfg.svh ----
// constants of the indexed configuration port
`ifndef ICP_CFG_SVH
`define ICP_CFG_SVH
`define ICP_ENTRY_KEY     8'h55
`define ICP_EXIT_KEY      8'hAA
`define ICP_LDN_IDX       8'h07
`define ICP_RSVD_A_LAST   8'h01
`define ICP_TEST_IDX      8'h02
`define ICP_RSVD_B_LAST   8'h06
`define ICP_RSVD_C_FIRST  8'h08
`define ICP_RSVD_C_LAST   8'h1F
`define ICP_RSVD_D_IDX    8'h24
`define ICP_BANK_FIRST    8'h30
`define ICP_NUM_LD        16
`define ICP_BANK_SIZE     208
`define ICP_LD_LIMIT      8'h10
`define ICP_GLOBAL_LDN    8'h3F
`define ICP_PORT_LDN      8'h0C
`define ICP_BAR_LO_IDX    8'h34
`define ICP_BAR_HI_IDX    8'h35
`define ICP_BAR_LO_RST    8'h2E
`define ICP_BAR_HI_RST    8'h00
`define ICP_DATA_OFS      16'h0001
`define ICP_INDEX_RST     8'h00
`define ICP_LDN_RST       8'h00
`define ICP_UNDEF_VAL     8'hFF
`define ICP_RSVD_VAL      8'h00
`define ICP_BYTE_RST      8'h00
`define ICP_ACT_OFF       8'h00
`define ICP_EC_BASE_HI    8'h00
`endif

// ---- logic/icp_pkg.sv ----
// types shared by the indexed configuration port
package icp_pkg;
  typedef enum logic [2:0] {
    LOC_UNDEF  = 3'h0,
    LOC_RSVD   = 3'h1,
    LOC_LDN    = 3'h2,
    LOC_BANK   = 3'h3,
    LOC_BAR_LO = 3'h4,
    LOC_BAR_HI = 3'h5
  } loc_kind_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_ON  = 2'h1
  } mode_state_t;
endpackage

// ---- logic/icp_mode_ctl.sv ----
// access state machine driven by key writes to the index address
`include "icp_cfg.svh"
module icp_mode_ctl (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       link_rst,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  output logic            mode_on
);
  icp_pkg::mode_state_t state_reg;
  icp_pkg::mode_state_t state_next;
  logic                 on_reg;
  logic                 on_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      icp_pkg::MODE_OFF: begin
        if (key_wr && key_data == `ICP_ENTRY_KEY) begin // RULE10
          state_next = icp_pkg::MODE_ON;
        end
      end
      icp_pkg::MODE_ON: begin
        if (key_wr && key_data == `ICP_EXIT_KEY) begin // RULE11
          state_next = icp_pkg::MODE_OFF;
        end
      end
      default: begin
        state_next = icp_pkg::MODE_OFF;
      end
    endcase
    if (link_rst) begin // RULE12
      state_next = icp_pkg::MODE_OFF;
    end
    // flag kept in its own flop so the access output leaves a register directly
    on_next = (state_next == icp_pkg::MODE_ON);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= icp_pkg::MODE_OFF; // RULE4
      on_reg    <= 1'b0; // RULE4
    end else begin
      state_reg <= state_next;
      on_reg    <= on_next;
    end
  end

  assign mode_on = on_reg;

  property p_link_rst_off;
    @(posedge clk) disable iff (rst)
    link_rst |=> !mode_on;
  endproperty
  a_link_rst_off: assert property (p_link_rst_off) else $error("access state survived link reset"); // RULE12
endmodule

// ---- logic/indexed_config_port.sv ----
// index/data configuration port with global and per-device banks
`include "icp_cfg.svh"
// Summary of operation
// RULE1: each device bank at indexes 30h..FFh
// RULE2: device select register picks answering bank
// RULE3: globals reachable whatever device is selected
// RULE4: access state off after reset
// RULE5: port has no effect while state off
// RULE6: index points, data moves that byte
// RULE7: untouched index reads location 00h
// RULE8: index at base, data base+1, 2Eh default
// RULE9: device Ch base register moves port
// RULE10: 55h to index enters access state
// RULE11: AAh to index leaves access state
// RULE12: system or link reset forces state off
// RULE13: 48 globals, up to 208 per device
// RULE14: host selects device, then index, data
// RULE15: host may skip selection for globals
// RULE16: undefined writes complete, change nothing
// RULE17: undefined reads return FFh
// RULE18: reserved globals ignore writes, read zero
// RULE19: globals also reachable under device 3Fh
// RULE20: controller reaches registers at base+index
// RULE21: activation touches only selected device
// RULE22: power-on reset restores every register
// RULE23: host enters, programs, then leaves state
// RULE24: other index writes load pointer when on
module indexed_config_port (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        HOST_LINK_RST,
  input  wire logic        SERIAL_LINK_RST,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic [7:0]  IO_WDATA,
  output logic      [7:0]  IO_RDATA,
  output logic             IO_RVALID,
  input  wire logic        EC_WR,
  input  wire logic        EC_RD,
  input  wire logic [15:0] EC_ADDR,
  input  wire logic [7:0]  EC_WDATA,
  output logic      [7:0]  EC_RDATA,
  output logic             EC_RVALID,
  output logic             CONFIG_MODE,
  output logic      [15:0] PORT_BASE,
  output logic      [7:0]  SELECTED_LD,
  output logic      [15:0] LD_ACTIVE
);
  logic [7:0]  bank_mem [0:`ICP_NUM_LD-1][0:`ICP_BANK_SIZE-1];
  logic [7:0]  index_reg;
  logic [7:0]  index_next;
  logic [7:0]  ldn_reg;
  logic [7:0]  ldn_next;
  logic [7:0]  bar_lo_reg;
  logic [7:0]  bar_lo_next;
  logic [7:0]  bar_hi_reg;
  logic [7:0]  bar_hi_next;
  logic [7:0]  io_rdata_reg;
  logic [7:0]  io_rdata_next;
  logic        io_rvalid_reg;
  logic        io_rvalid_next;
  logic [7:0]  ec_rdata_reg;
  logic [7:0]  ec_rdata_next;
  logic        ec_rvalid_reg;
  logic        ec_rvalid_next;
  logic        mode_on;
  logic        link_rst;
  logic [15:0] base_addr;
  logic        idx_hit;
  logic        dat_hit;
  logic        ec_hit;
  logic        host_we;
  logic        ec_we;
  logic        wr_en;
  logic [7:0]  wr_idx;
  logic [7:0]  wr_data;
  icp_pkg::loc_kind_t host_kind;
  icp_pkg::loc_kind_t ec_kind;
  icp_pkg::loc_kind_t wr_kind;

  // classify a location for the current device selection
  function automatic icp_pkg::loc_kind_t decode_loc(input logic [7:0] ldn, input logic [7:0] idx);
    icp_pkg::loc_kind_t k;
    k = icp_pkg::LOC_UNDEF;
    if (idx < `ICP_BANK_FIRST) begin // RULE3 RULE13 RULE19
      if (idx == `ICP_LDN_IDX) begin
        k = icp_pkg::LOC_LDN;
      end else if (idx <= `ICP_RSVD_A_LAST ||
                   (idx > `ICP_TEST_IDX && idx <= `ICP_RSVD_B_LAST) ||
                   (idx >= `ICP_RSVD_C_FIRST && idx <= `ICP_RSVD_C_LAST) ||
                   idx == `ICP_RSVD_D_IDX) begin // RULE18
        k = icp_pkg::LOC_RSVD;
      end
    end else if (ldn == `ICP_PORT_LDN && idx == `ICP_BAR_LO_IDX) begin // RULE9
      k = icp_pkg::LOC_BAR_LO;
    end else if (ldn == `ICP_PORT_LDN && idx == `ICP_BAR_HI_IDX) begin
      k = icp_pkg::LOC_BAR_HI;
    end else if (ldn < `ICP_LD_LIMIT) begin // RULE1 RULE2
      k = icp_pkg::LOC_BANK;
    end
    return k;
  endfunction

  // offset into a device bank; globals map to 0 to keep the index in range
  function automatic logic [7:0] bank_off(input logic [7:0] idx);
    return (idx >= `ICP_BANK_FIRST) ? 8'(idx - `ICP_BANK_FIRST) : `ICP_BYTE_RST;
  endfunction

  function automatic logic [7:0] read_loc(input icp_pkg::loc_kind_t k, input logic [7:0] ldn,
                                         input logic [7:0] blo, input logic [7:0] bhi,
                                         input logic [7:0] bank_byte);
    logic [7:0] v;
    v = `ICP_UNDEF_VAL; // RULE17
    case (k)
      icp_pkg::LOC_RSVD:   v = `ICP_RSVD_VAL; // RULE18
      icp_pkg::LOC_LDN:    v = ldn;
      icp_pkg::LOC_BAR_LO: v = blo;
      icp_pkg::LOC_BAR_HI: v = bhi;
      icp_pkg::LOC_BANK:   v = bank_byte;
      default:             v = `ICP_UNDEF_VAL;
    endcase
    return v;
  endfunction

  assign link_rst  = HOST_LINK_RST | SERIAL_LINK_RST;
  assign base_addr = {bar_hi_reg, bar_lo_reg};
  assign idx_hit   = (IO_ADDR == base_addr); // RULE8
  assign dat_hit   = (IO_ADDR == 16'(base_addr + `ICP_DATA_OFS));
  assign ec_hit    = (EC_ADDR[15:8] == `ICP_EC_BASE_HI); // RULE20
  assign host_kind = decode_loc(ldn_reg, index_reg);
  assign ec_kind   = decode_loc(ldn_reg, EC_ADDR[7:0]);

  icp_mode_ctl u_mode (
    .clk      (SYS_CLK),
    .rst      (RST),
    .link_rst (link_rst),
    .key_wr   (IO_WR && idx_hit),
    .key_data (IO_WDATA),
    .mode_on  (mode_on)
  );

  // host data writes win a same-cycle collision with the controller
  always_comb begin
    host_we = mode_on && IO_WR && dat_hit; // RULE5 RULE6
    ec_we   = EC_WR && ec_hit && !host_we;
    wr_en   = host_we || ec_we;
    wr_idx  = host_we ? index_reg : EC_ADDR[7:0];
    wr_data = host_we ? IO_WDATA : EC_WDATA;
    wr_kind = host_we ? host_kind : ec_kind;
  end

  always_comb begin
    index_next  = index_reg;
    ldn_next    = ldn_reg;
    bar_lo_next = bar_lo_reg;
    bar_hi_next = bar_hi_reg;
    if (mode_on && IO_WR && idx_hit && IO_WDATA != `ICP_EXIT_KEY) begin // RULE24
      index_next = IO_WDATA;
    end
    if (wr_en) begin // RULE16
      case (wr_kind)
        icp_pkg::LOC_LDN:    ldn_next = wr_data; // RULE2
        icp_pkg::LOC_BAR_LO: bar_lo_next = wr_data; // RULE9
        icp_pkg::LOC_BAR_HI: bar_hi_next = wr_data;
        default:             ldn_next = ldn_reg;
      endcase
    end
    if (link_rst) begin
      index_next = `ICP_INDEX_RST;
    end
  end

  always_comb begin
    io_rvalid_next = IO_RD && (idx_hit || dat_hit);
    io_rdata_next  = `ICP_UNDEF_VAL; // RULE5
    if (IO_RD && mode_on && idx_hit) begin
      io_rdata_next = index_reg;
    end else if (IO_RD && mode_on && dat_hit) begin // RULE6 RULE7
      io_rdata_next = read_loc(host_kind, ldn_reg, bar_lo_reg, bar_hi_reg,
                               bank_mem[ldn_reg[3:0]][bank_off(index_reg)]);
    end
    ec_rvalid_next = EC_RD && ec_hit;
    ec_rdata_next  = `ICP_UNDEF_VAL;
    if (EC_RD && ec_hit) begin // RULE20
      ec_rdata_next = read_loc(ec_kind, ldn_reg, bar_lo_reg, bar_hi_reg,
                               bank_mem[ldn_reg[3:0]][bank_off(EC_ADDR[7:0])]);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin // RULE22
      index_reg     <= `ICP_INDEX_RST; // RULE8
      ldn_reg       <= `ICP_LDN_RST;
      bar_lo_reg    <= `ICP_BAR_LO_RST;
      bar_hi_reg    <= `ICP_BAR_HI_RST;
      io_rdata_reg  <= `ICP_BYTE_RST;
      io_rvalid_reg <= 1'b0;
      ec_rdata_reg  <= `ICP_BYTE_RST;
      ec_rvalid_reg <= 1'b0;
    end else begin
      index_reg     <= index_next;
      ldn_reg       <= ldn_next;
      bar_lo_reg    <= bar_lo_next;
      bar_hi_reg    <= bar_hi_next;
      io_rdata_reg  <= io_rdata_next;
      io_rvalid_reg <= io_rvalid_next;
      ec_rdata_reg  <= ec_rdata_next;
      ec_rvalid_reg <= ec_rvalid_next;
    end
  end

  // banks are flops rather than RAM so power-on reset can clear them
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin // RULE22
      for (int d = 0; d < `ICP_NUM_LD; d++) begin
        for (int i = 0; i < `ICP_BANK_SIZE; i++) begin
          bank_mem[d][i] <= `ICP_BYTE_RST;
        end
      end
    end else if (wr_en && wr_kind == icp_pkg::LOC_BANK) begin // RULE21
      bank_mem[ldn_reg[3:0]][bank_off(wr_idx)] <= wr_data;
    end
  end

  always_comb begin
    for (int d = 0; d < `ICP_NUM_LD; d++) begin
      LD_ACTIVE[d] = bank_mem[d][`ICP_ACT_OFF][0]; // RULE21
    end
  end

  assign IO_RDATA    = io_rdata_reg;
  assign IO_RVALID   = io_rvalid_reg;
  assign EC_RDATA    = ec_rdata_reg;
  assign EC_RVALID   = ec_rvalid_reg;
  assign CONFIG_MODE = mode_on;
  assign PORT_BASE   = base_addr;
  assign SELECTED_LD = ldn_reg;

  property p_entry;
    @(posedge SYS_CLK) disable iff (RST)
    (!mode_on && IO_WR && idx_hit && IO_WDATA == `ICP_ENTRY_KEY && !link_rst) |=> mode_on;
  endproperty
  a_entry: assert property (p_entry) else $error("entry key did not open access"); // RULE10

  property p_exit;
    @(posedge SYS_CLK) disable iff (RST)
    (mode_on && IO_WR && idx_hit && IO_WDATA == `ICP_EXIT_KEY) |=> !mode_on;
  endproperty
  a_exit: assert property (p_exit) else $error("exit key did not close access"); // RULE11

  property p_off_inert;
    @(posedge SYS_CLK) disable iff (RST)
    (!mode_on && !EC_WR && IO_WR && (dat_hit || idx_hit)) |=> ($stable(ldn_reg) && $stable(base_addr));
  endproperty
  a_off_inert: assert property (p_off_inert) else $error("port changed state while closed"); // RULE5

  property p_index_load;
    @(posedge SYS_CLK) disable iff (RST)
    (mode_on && IO_WR && idx_hit && IO_WDATA != `ICP_EXIT_KEY && !link_rst) |=> index_reg == $past(IO_WDATA);
  endproperty
  a_index_load: assert property (p_index_load) else $error("index pointer not loaded"); // RULE24

  property p_ldn_write;
    @(posedge SYS_CLK) disable iff (RST)
    (host_we && index_reg == `ICP_LDN_IDX) |=> (SELECTED_LD == $past(IO_WDATA));
  endproperty
  a_ldn_write: assert property (p_ldn_write) else $error("device select not written"); // RULE2

  property p_undef_read;
    @(posedge SYS_CLK) disable iff (RST)
    (IO_RD && dat_hit && mode_on && host_kind == icp_pkg::LOC_UNDEF) |=> (IO_RVALID && IO_RDATA == `ICP_UNDEF_VAL);
  endproperty
  a_undef_read: assert property (p_undef_read) else $error("undefined read not FFh"); // RULE17

  property p_rsvd_read;
    @(posedge SYS_CLK) disable iff (RST)
    (IO_RD && dat_hit && mode_on && host_kind == icp_pkg::LOC_RSVD) |=> (IO_RVALID && IO_RDATA == `ICP_RSVD_VAL);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read not zero"); // RULE18

  property p_bar_move;
    @(posedge SYS_CLK) disable iff (RST)
    (host_we && host_kind == icp_pkg::LOC_BAR_LO) |=> (PORT_BASE[7:0] == $past(IO_WDATA));
  endproperty
  a_bar_move: assert property (p_bar_move) else $error("port base not relocated"); // RULE9

  property p_link_idx;
    @(posedge SYS_CLK) disable iff (RST)
    link_rst |=> (index_reg == `ICP_INDEX_RST && !CONFIG_MODE);
  endproperty
  a_link_idx: assert property (p_link_idx) else $error("link reset left port open"); // RULE12
endmodule

// ---- tb/icp_host_model.sv ----
// host chipset model issuing single-byte I/O cycles on the port
module icp_host_model (
  input  wire logic        clk,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [15:0] io_addr,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  // released lines go inverted so a stale address never looks valid
  task automatic io_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
    q = 8'h00;
    ok = 1'b0;
    @(negedge clk);
    io_wr <= wr;
    io_rd <= !wr;
    io_addr <= a;
    io_wdata <= d;
    @(negedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    for (int i = 0; i < 3 && !wr && !ok; i++) begin
      if (io_rvalid === 1'b1) begin
        q = io_rdata;
        ok = 1'b1;
      end else begin
        @(negedge clk);
      end
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       ok;
    io_cycle(1'b1, a, d, q, ok);
  endtask
  // device first, then pointer and data
  task automatic select_ld(input logic [15:0] b, input logic [7:0] ld);
    put(b, 8'h07);
    put(b + 16'h0001, ld);
  endtask
  // globals need no selection step
  task automatic point(input logic [15:0] b, input logic [7:0] idx);
    put(b, idx);
  endtask
  // entry and exit keys bracket a session
  task automatic key(input logic [15:0] b, input logic [7:0] k);
    put(b, k);
  endtask
endmodule

// ---- tb/indexed_config_port_tb.sv ----
// self-checking bench for the indexed configuration port
`include "icp_cfg.svh"
module indexed_config_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        rst;
  logic        host_link_rst;
  logic        serial_link_rst;
  logic        io_wr;
  logic        io_rd;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_rvalid;
  logic        ec_wr;
  logic        ec_rd;
  logic [15:0] ec_addr;
  logic [7:0]  ec_wdata;
  logic [7:0]  ec_rdata;
  logic        ec_rvalid;
  logic        config_mode;
  logic [15:0] port_base;
  logic [7:0]  selected_ld;
  logic [15:0] ld_active;
  logic [15:0] b;
  int          bad_count;
  int          num_checks;
  logic [7:0]  rsv_idx [6] = '{8'h01, 8'h02, 8'h05, 8'h24, 8'h1F, 8'h2F};
  logic [7:0]  rsv_val [6] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF};
  indexed_config_port indexed_config_port_i (
    .SYS_CLK(sys_clk), .RST(rst), .HOST_LINK_RST(host_link_rst), .SERIAL_LINK_RST(serial_link_rst),
    .IO_WR(io_wr), .IO_RD(io_rd), .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
    .IO_RVALID(io_rvalid), .EC_WR(ec_wr), .EC_RD(ec_rd), .EC_ADDR(ec_addr), .EC_WDATA(ec_wdata),
    .EC_RDATA(ec_rdata), .EC_RVALID(ec_rvalid), .CONFIG_MODE(config_mode), .PORT_BASE(port_base),
    .SELECTED_LD(selected_ld), .LD_ACTIVE(ld_active)
  );
  icp_host_model icp_host_model_i (
    .clk(sys_clk), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [47:0] act, input logic [47:0] exp, input string s);
    num_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, s, act, exp);
    end
  endtask
  // a missing answer counts as a mismatch when one is expected, never a hang
  task automatic rd(input logic [15:0] a, input logic ev, input logic [7:0] e, input string s);
    logic [7:0] q;
    logic       ok;
    icp_host_model_i.io_cycle(1'b0, a, 8'h00, q, ok);
    check(ok, ev, s);
    if (ev) check(q, e, s);
  endtask
  task automatic ird(input logic [7:0] i, input logic [7:0] e, input string s);
    icp_host_model_i.point(b, i);
    rd(b + 16'h0001, 1'b1, e, s);
  endtask
  task automatic iwr(input logic [7:0] i, input logic [7:0] d);
    icp_host_model_i.point(b, i);
    icp_host_model_i.put(b + 16'h0001, d);
  endtask
  task automatic ec(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [7:0] e);
    @(negedge sys_clk);
    ec_wr = w;
    ec_rd = !w;
    ec_addr = {`ICP_EC_BASE_HI, i};
    ec_wdata = d;
    @(negedge sys_clk);
    ec_wr = 1'b0;
    ec_rd = 1'b0;
    ec_addr = ~ec_addr;
    ec_wdata = ~d;
    if (!w) check({ec_rvalid, ec_rdata}, {1'b1, e}, "ec read");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    host_link_rst = 1'b0;
    serial_link_rst = 1'b0;
    ec_wr = 1'b0;
    ec_rd = 1'b0;
    ec_addr = 16'h0000;
    ec_wdata = 8'h00;
    bad_count = 0;
    num_checks = 0;
    b = 16'h002E;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    check({config_mode, port_base, selected_ld}, {1'b0, 16'h002E, 8'h00}, "reset");
    iwr(8'h07, 8'h09);
    icp_host_model_i.key(b, `ICP_EXIT_KEY);
    check({config_mode, selected_ld}, 9'h000, "port while off");
    rd(16'h002F, 1'b1, 8'hFF, "data off");
    icp_host_model_i.key(b, `ICP_ENTRY_KEY);
    check(config_mode, 1'b1, "entry");
    rd(16'h002F, 1'b1, 8'h00, "location 00h");
    for (int k = 0; k < 6; k++) begin
      iwr(rsv_idx[k], 8'h5A);
      ird(rsv_idx[k], rsv_val[k], "reserved");
    end
    check(selected_ld, 8'h00, "reserved write");
    icp_host_model_i.select_ld(b, 8'h03);
    check(selected_ld, 8'h03, "select");
    iwr(8'h30, 8'h01);
    iwr(8'hFF, 8'h77);
    check(ld_active, 16'h0008, "activate");
    icp_host_model_i.select_ld(b, 8'h05);
    ird(8'hFF, 8'h00, "ld5 bank");
    ird(8'h07, 8'h05, "global");
    icp_host_model_i.select_ld(b, 8'h03);
    ird(8'hFF, 8'h77, "ld3 bank");
    icp_host_model_i.select_ld(b, `ICP_GLOBAL_LDN);
    ird(8'h07, 8'h3F, "global ldn");
    ird(8'h30, 8'hFF, "undefined bank");
    iwr(8'h30, 8'h00);
    check(ld_active, 16'h0008, "undefined write");
    ec(1'b0, 8'h07, 8'h00, 8'h3F);
    ec(1'b1, 8'h07, 8'h0C, 8'h00);
    check(selected_ld, 8'h0C, "ec select");
    iwr(8'h34, 8'h4E);
    check(port_base, 16'h004E, "relocate");
    rd(16'h002E, 1'b0, 8'h00, "old base");
    b = 16'h004E;
    ird(8'h34, 8'h4E, "new base");
    iwr(8'h35, 8'h01);
    b = 16'h014E;
    ird(8'h35, 8'h01, "base high");
    icp_host_model_i.key(b, `ICP_EXIT_KEY);
    check(config_mode, 1'b0, "exit");
    for (int k = 0; k < 2; k++) begin
      icp_host_model_i.key(b, `ICP_ENTRY_KEY);
      check(config_mode, 1'b1, "reentry");
      @(negedge sys_clk);
      host_link_rst = (k == 0);
      serial_link_rst = (k == 1);
      @(negedge sys_clk);
      host_link_rst = 1'b0;
      serial_link_rst = 1'b0;
      check({config_mode, port_base}, {1'b0, 16'h014E}, "link reset");
    end
    // pointer held 35h before the link resets; a kept pointer would read 01h here
    icp_host_model_i.key(b, `ICP_ENTRY_KEY);
    rd(b + 16'h0001, 1'b1, 8'h00, "index cleared");
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    check({config_mode, port_base, selected_ld, ld_active},
          {1'b0, 16'h002E, 8'h00, 16'h0000}, "power reset");
    summarize();
  end
endmodule
